//--- verilog/sarc_cfg.svh
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH
// Overview of operation
// R1: A start strobe during a conversion abandons it and starts afresh.
// R2: An aborted conversion leaves the result latch unchanged.
// R3: On restart the active-low completion flag stays high for the abandoned run.
// R4: Free-running use ties select low and write to the completion output.
// R5: Free-running use needs one forced low pulse on write after power-up.
// R6: Conversion clock comes from host clock or from the on-chip RC oscillator; this design takes it only from clk through the DIV divider.
// R7: Result is an 8-bit unsigned code, one step equals span over 256.
// R8: Host lengthens bus cycles under heavy load and fast clocks.
// R9: Host drives select, read and write straight from its bus strobes.
// R10: Completion loads the latch and drops the flag; read or start raises it.
// R11: Data bus is driven only while select and read are both low; this design follows them through two sync stages and an output register.
`define SARC_DATA_W     8
`define SARC_RESULT_RST 8'h00
`define SARC_CONV_DIV   4
`endif

//--- verilog/sarc_pkg.sv
package sarc_pkg;
   typedef enum logic [1:0] {
      SARC_IDLE = 2'b00,
      SARC_CONV = 2'b01
   } sarc_state_t;
   typedef struct packed {
      logic csN;
      logic rdN;
      logic wrN;
   } sarc_strobe_t;
endpackage

//--- verilog/sarc_sync.sv
`timescale 1ns/10ps
module sarc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] sync
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= '1;
         sync   <= '1;
      end else begin
         meta_q <= async;
         sync   <= meta_q;
      end
   end
endmodule

//--- verilog/sarc_top.sv
`timescale 1ns/10ps
`include "sarc_cfg.svh"
module sarc_top import sarc_pkg::*; #(
   parameter int DIV = `SARC_CONV_DIV
) (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire sarc_strobe_t             strobeN,
   input  wire logic                     compIn,
   output logic                          doneIrqN,
   output logic [`SARC_DATA_W-1:0]       dataOut,
   output logic                          dataOeN,
   output logic [`SARC_DATA_W-1:0]       trialCode
);
   // ====================================================
   // Pin synchronisation
   // ====================================================
   // Comparator answer trails the trial code by one output register and two sync stages,
   // so a bit may only be decided after four clocks; the divider counter is 16 bits wide
   if (DIV < 4 || DIV > 65536) begin : g_divCheck
      $error("DIV must lie between 4 and 65536");
   end
   logic [3:0] pinSync;
   sarc_sync #(.WIDTH(4)) uSync (
      .clk   (clk),
      .reset (reset),
      .async ({strobeN.csN, strobeN.rdN, strobeN.wrN, compIn}),
      .sync  (pinSync)
   );
   logic csN, rdN, wrN, comp;
   assign {csN, rdN, wrN, comp} = pinSync;
   // ====================================================
   // Strobe decode
   // ====================================================
   logic wrAct_q, startPulse, readAct;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) wrAct_q <= 1'b0;
      else       wrAct_q <= ~csN & ~wrN;
   end
   // Start fires on the rising edge so the run begins after the strobe ends
   assign startPulse = wrAct_q & ~(~csN & ~wrN); // [R1]
   assign readAct    = ~csN & ~rdN;
   // ====================================================
   // Sequencer, conversion clock from clk by divider
   // ====================================================
   sarc_state_t state_q;
   logic [7:0]  sar_q, result_q;
   logic [2:0]  bit_q;
   logic [15:0] div_q;
   logic        tick;
   assign tick = (div_q == 16'(DIV - 1)); // [R6]
   always_ff @(posedge clk or posedge reset) begin
      if (reset)                          div_q <= 16'h0000;
      else if (startPulse || tick)        div_q <= 16'h0000;
      else                                div_q <= div_q + 16'h0001;
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= SARC_IDLE;
         sar_q   <= 8'h80;
         bit_q   <= 3'h7;
      end else if (startPulse) begin
         state_q <= SARC_CONV; // [R1]
         sar_q   <= 8'h80;
         bit_q   <= 3'h7;
      end else if (state_q == SARC_CONV && tick) begin
         case (bit_q)
            3'h0: begin
               state_q <= SARC_IDLE;
            end
            default: begin
               bit_q <= bit_q - 3'h1;
               sar_q <= sar_q | (8'h01 << (bit_q - 3'h1));
            end
         endcase
         // Comparator says trial too high: drop the bit just tried
         if (!comp) sar_q[bit_q] <= 1'b0; // [R7]
      end
   end
   logic doneEv;
   assign doneEv = (state_q == SARC_CONV) && tick && (bit_q == 3'h0) && !startPulse;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) result_q <= `SARC_RESULT_RST;
      else if (doneEv) result_q <= {sar_q[7:1], comp ? sar_q[0] : 1'b0}; // [R10] [R2]
   end
   // ====================================================
   // Completion flag, bus outputs
   // ====================================================
   always_ff @(posedge clk or posedge reset) begin
      if (reset)           doneIrqN <= 1'b1;
      else if (doneEv)     doneIrqN <= 1'b0; // [R10]
      else if (startPulse) doneIrqN <= 1'b1; // [R3]
      else if (readAct)    doneIrqN <= 1'b1; // [R10]
      else if (wrAct_q)    doneIrqN <= 1'b1; // [R3]
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dataOeN   <= 1'b1;
         dataOut   <= 8'h00;
         trialCode <= 8'h00;
      end else begin
         dataOeN   <= ~readAct; // [R11]
         dataOut   <= readAct ? result_q : 8'h00;
         trialCode <= sar_q;
      end
   end
   // ====================================================
   // Checks
   // ====================================================
   property p_restart;
      @(posedge clk) disable iff (reset) startPulse |=> state_q == SARC_CONV && bit_q == 3'h7;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not reset sequencer"); // [R1]
   property p_keep;
      @(posedge clk) disable iff (reset) !doneEv |=> $stable(result_q);
   endproperty
   a_keep: assert property (p_keep) else $error("result changed without completion"); // [R2]
   property p_nodone;
      @(posedge clk) disable iff (reset) startPulse |=> doneIrqN;
   endproperty
   a_nodone: assert property (p_nodone) else $error("flag low after restart"); // [R3]
   property p_done;
      @(posedge clk) disable iff (reset) doneEv |=> !doneIrqN && state_q == SARC_IDLE;
   endproperty
   a_done: assert property (p_done) else $error("completion not signalled"); // [R10]
   property p_oe;
      @(posedge clk) disable iff (reset) !dataOeN |-> $past(readAct);
   endproperty
   a_oe: assert property (p_oe) else $error("bus driven without read"); // [R11]
   property p_tick;
      @(posedge clk) disable iff (reset) tick |=> div_q == 16'h0000;
   endproperty
   a_tick: assert property (p_tick) else $error("divider not wrapped"); // [R6]
   property p_msb;
      @(posedge clk) disable iff (reset) startPulse |=> sar_q == 8'h80;
   endproperty
   a_msb: assert property (p_msb) else $error("trial does not start at midscale"); // [R7]
   property p_rel;
      @(posedge clk) disable iff (reset) (readAct && !doneEv) |=> doneIrqN;
   endproperty
   a_rel: assert property (p_rel) else $error("read did not release flag"); // [R10]
   // ====================================================
   // Further checks on sequencer, flag and bus outputs
   // ====================================================
   property p_idleHold;
      @(posedge clk) disable iff (reset) (state_q == SARC_IDLE && !startPulse) |=> state_q == SARC_IDLE;
   endproperty
   a_idleHold: assert property (p_idleHold) else $error("sequencer left idle without start"); // [R1]

   property p_legal;
      @(posedge clk) disable iff (reset) state_q == SARC_IDLE || state_q == SARC_CONV;
   endproperty
   a_legal: assert property (p_legal) else $error("sequencer in unknown state"); // [R1]

   property p_bitStep;
      @(posedge clk) disable iff (reset)
         (state_q == SARC_CONV && tick && bit_q != 3'h0 && !startPulse) |=> bit_q == $past(bit_q) - 3'h1;
   endproperty
   a_bitStep: assert property (p_bitStep) else $error("trial bit did not step down"); // [R7]

   property p_divRun;
      @(posedge clk) disable iff (reset) (!tick && !startPulse) |=> div_q == $past(div_q) + 16'h0001;
   endproperty
   a_divRun: assert property (p_divRun) else $error("divider did not count"); // [R6]

   property p_divRange;
      @(posedge clk) disable iff (reset) div_q <= 16'(DIV - 1);
   endproperty
   a_divRange: assert property (p_divRange) else $error("divider out of range"); // [R6]

   property p_oeData;
      @(posedge clk) disable iff (reset) !dataOeN |-> dataOut == $past(result_q);
   endproperty
   a_oeData: assert property (p_oeData) else $error("bus shows other than the latch"); // [R11]

   property p_quiet;
      @(posedge clk) disable iff (reset) dataOeN |-> dataOut == 8'h00;
   endproperty
   a_quiet: assert property (p_quiet) else $error("data present while bus released"); // [R11]

   property p_flagHold;
      @(posedge clk) disable iff (reset) (!doneIrqN && !startPulse && !readAct && !wrAct_q) |=> !doneIrqN;
   endproperty
   a_flagHold: assert property (p_flagHold) else $error("flag released without read or start"); // [R10]

   property p_flagHigh;
      @(posedge clk) disable iff (reset) (doneIrqN && !doneEv) |=> doneIrqN;
   endproperty
   a_flagHigh: assert property (p_flagHigh) else $error("flag dropped without completion"); // [R3]

   property p_wrRaise;
      @(posedge clk) disable iff (reset) (wrAct_q && !doneEv) |=> doneIrqN;
   endproperty
   a_wrRaise: assert property (p_wrRaise) else $error("write strobe did not raise flag"); // [R3]

   c_done:    cover property (@(posedge clk) doneEv);
   c_late:    cover property (@(posedge clk) startPulse && state_q == SARC_CONV && bit_q == 3'h0);
   c_restart: cover property (@(posedge clk) startPulse && state_q == SARC_CONV);
   c_read:    cover property (@(posedge clk) readAct && !doneIrqN);
endmodule

//--- verification/sarc_host_model.sv
`timescale 1ns/10ps
module sarc_host_model import sarc_pkg::*; (
   input  wire logic       clk,
   input  wire logic       doneIrqN,
   input  wire logic [7:0] dataOut,
   input  wire logic       dataOeN,
   input  wire logic [7:0] trialCode,
   output sarc_strobe_t    strobeN,
   output logic            compIn
);
   // ==========
   // Bus and analog side
   sarc_strobe_t busQ    = 3'h7;
   logic         freeRun = 1'b0;
   logic         kickN   = 1'b1;
   logic [7:0]   vin     = 8'h00;
   // Select grounded, write joined to completion, kick once
   assign strobeN = freeRun ? {1'b0, 1'b1, doneIrqN & kickN} : busQ;
   // Ideal comparator, code step of span over 256
   assign compIn = (vin >= trialCode);
   // Write strobe held 3 clocks, read strobe 4, so the synchronisers see them
   task automatic hostWrite();
      @(posedge clk);
      #1 busQ = 3'h2;
      repeat (3) @(posedge clk);
      #1 busQ = 3'h7;
   endtask
   task automatic hostRead(output logic [7:0] res, output logic oeN);
      @(posedge clk);
      #1 busQ = 3'h1;
      repeat (4) @(posedge clk);
      #1 res = dataOut;
      oeN = dataOeN;
      busQ = 3'h7;
      repeat (5) @(posedge clk);
      #1;
   endtask
endmodule

//--- verification/sar_conversion_start_control_tb_top.sv
`timescale 1ns/10ps
module sar_conversion_start_control_tb_top import sarc_pkg::*; ();
   logic         clk   = 1'b0;
   logic         reset = 1'b1;
   sarc_strobe_t strobeN;
   logic         compIn, doneIrqN, dataOeN, oeN;
   logic [7:0]   dataOut, trialCode, res;
   int           n_mismatch = 0;
   int           n_checks   = 0;
   int           lastRes    = 0;
   int           nDone      = 0;
   int           waitK;
   always #2.5 clk = ~clk;
   always @(negedge doneIrqN) nDone++;
   sarc_top #(.DIV(4)) dut (.clk(clk), .reset(reset), .strobeN(strobeN), .compIn(compIn),
      .doneIrqN(doneIrqN), .dataOut(dataOut), .dataOeN(dataOeN), .trialCode(trialCode));
   sarc_host_model host (.clk(clk), .doneIrqN(doneIrqN), .dataOut(dataOut), .dataOeN(dataOeN),
      .trialCode(trialCode), .strobeN(strobeN), .compIn(compIn));
   // ==========
   // Checking
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpBit(input logic got, input logic exp);
      cmp({7'h00, got}, {7'h00, exp});
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Bounded wait; a full conversion is 8 ticks of 4 clocks
   task automatic convRead(input logic [7:0] v);
      host.vin = v;
      host.hostWrite();
      waitK = 0;
      while (doneIrqN !== 1'b0 && waitK < 90) begin
         @(posedge clk);
         #1 waitK++;
      end
      #1 cmpBit(doneIrqN, 1'b0);
      cmpBit(waitK > 28, 1'b1);
      lastRes = v;
      host.hostRead(res, oeN);
      cmp(res, lastRes[7:0]);
      cmpBit(oeN, 1'b0);
      cmpBit(dataOeN, 1'b1);
      cmpBit(doneIrqN, 1'b1);
   endtask
   // ==========
   // Scenarios
   initial begin
      void'($urandom(91));
      repeat (10) @(posedge clk);
      #1 reset = 1'b0;
      cmpBit(doneIrqN, 1'b1);
      convRead(8'h00);
      convRead(8'hFF);
      repeat (5) convRead(8'($urandom));
      // Abort at several depths; the old result must survive
      for (int a = 3; a < 18; a += 3) begin
         host.vin = 8'($urandom);
         host.hostWrite();
         repeat (a) @(posedge clk);
         #1 cmpBit(doneIrqN, 1'b1);
         host.vin = 8'($urandom);
         host.hostWrite();
         host.hostRead(res, oeN);
         cmp(res, lastRes[7:0]);
         convRead(8'($urandom));
      end
      nDone = 0;
      host.freeRun = 1'b1;
      host.kickN = 1'b0;
      repeat (3) @(posedge clk);
      #1 host.kickN = 1'b1;
      repeat (200) @(posedge clk);
      cmpBit(nDone >= 3, 1'b1);
      finish_test();
   end
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
endmodule
